// >>> verilog/pld_lut_map.svh
// Offsets, field positions, reset values and codes of the lookup block.
`ifndef PLD_LUT_MAP_SVH
`define PLD_LUT_MAP_SVH

`define PLD_LUT_BASE_ADDR 8'h28
`define PLD_UPPER_FIRST_ADDR 8'h28
`define PLD_LOWER_FIRST_ADDR 8'h29
`define PLD_UPPER_SECOND_ADDR 8'h2A
`define PLD_LOWER_SECOND_ADDR 8'h2B
`define PLD_ADV_ADDR 8'hAD
`define PLD_PIN_VALUE_ADDR 8'h10
`define PLD_IRQ_FLAGS_ADDR 8'h11
`define PLD_LUT_COUNT 8'h04
`define PLD_LUT_RESET 8'h00
`define PLD_ADV_RESET 8'h00
`define PLD_ADV_AUTOCLR_BIT 2
`define PLD_ADV_BOOST_BIT 1
`define PLD_ADV_WRITE_MASK 8'h06
`define PLD_IRQ_CLEAR_ALL 8'hFF
`define PLD_IRQ_CLEAR_NONE 8'h00
`define PLD_UNMAPPED_READ 8'h00
`define PLD_MODE_3TO2 2'h2

`endif

// >>> verilog/pld_lut_pkg.sv
// Types shared by the lookup block and its users.
package pld_lut_pkg;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef logic [7:0] lut_byte_t;

endpackage

// >>> verilog/pld_lut_select.sv
// One 3-to-1 table lookup, gated by its bank's mode.
`timescale 1ns/1ps
module pld_lut_select #(
    parameter int SEL_W = 3
)(
    // Table and selection.
    input wire logic [(1<<SEL_W)-1:0] i_table,
    input wire logic [SEL_W-1:0] i_sel,
    // Bank enable.
    input wire logic i_en,
    // Result.
    output logic o_bit
);
    always_comb
    begin
        o_bit = 1'b0;
        if (i_en)
        begin
            o_bit = i_table[i_sel];
        end
    end
endmodule

// >>> verilog/pld_lut_regs.sv
// Lookup tables and advanced settings of the expander's logic block.
`timescale 1ns/1ps
`include "pld_lut_map.svh"
module pld_lut_regs #(
    parameter int SEL_W = 3,
    parameter int MODE_W = 2
)(
    // Clock, reset and clock enable.
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Register access from the serial slave.
    input wire pld_lut_pkg::reg_req_t i_req,
    output logic [7:0] o_reg_rdata,
    // Selection pins and bank modes.
    input wire logic [SEL_W-1:0] i_upper_sel_pins,
    input wire logic [SEL_W-1:0] i_lower_sel_pins,
    input wire logic [MODE_W-1:0] i_upper_bank_logic_mode,
    input wire logic [MODE_W-1:0] i_lower_bank_logic_mode,
    // Lookup results: bit 0 pin 11, 1 pin 3, 2 pin 12, 3 pin 4.
    output logic [3:0] o_lut_out,
    output logic [3:0] o_lut_oe,
    // Settings and interrupt flag clearing.
    output logic o_boost_en,
    output logic [7:0] o_irq_clear_mask
);
    import pld_lut_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [SEL_W-1:0] up_s1_r;
    logic [SEL_W-1:0] up_s2_r;
    logic [SEL_W-1:0] lo_s1_r;
    logic [SEL_W-1:0] lo_s2_r;
    logic [SEL_W-1:0] up_s1_nxt;
    logic [SEL_W-1:0] up_s2_nxt;
    logic [SEL_W-1:0] lo_s1_nxt;
    logic [SEL_W-1:0] lo_s2_nxt;

    always_comb
    begin
        up_s1_nxt = up_s1_r;
        up_s2_nxt = up_s2_r;
        lo_s1_nxt = lo_s1_r;
        lo_s2_nxt = lo_s2_r;
        if (i_ce)
        begin
            up_s1_nxt = i_upper_sel_pins;
            up_s2_nxt = up_s1_r;
            lo_s1_nxt = i_lower_sel_pins;
            lo_s2_nxt = lo_s1_r;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            up_s1_r <= '0;
            up_s2_r <= '0;
            lo_s1_r <= '0;
            lo_s2_r <= '0;
        end
        else
        begin
            up_s1_r <= up_s1_nxt;
            up_s2_r <= up_s2_nxt;
            lo_s1_r <= lo_s1_nxt;
            lo_s2_r <= lo_s2_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    lut_byte_t lut_r [0:3];
    lut_byte_t lut_nxt [0:3];
    logic [7:0] adv_r;
    logic [7:0] adv_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] clr_r;
    logic [7:0] clr_nxt;
    logic [7:0] lut_off;
    logic lut_hit;
    logic [1:0] lut_idx;

    assign lut_off = i_req.addr - `PLD_LUT_BASE_ADDR;
    assign lut_hit = lut_off < `PLD_LUT_COUNT;
    assign lut_idx = lut_off[1:0];

    always_comb
    begin
        lut_nxt = lut_r;
        adv_nxt = adv_r;
        rdata_nxt = rdata_r;
        clr_nxt = `PLD_IRQ_CLEAR_NONE;
        if (i_ce && i_req.wr)
        begin
            if (lut_hit)
            begin
                lut_nxt[lut_idx] = i_req.wdata;
            end
            // Reserved bits are not stored and read back as zero.
            if (i_req.addr == `PLD_ADV_ADDR)
            begin
                adv_nxt = i_req.wdata & `PLD_ADV_WRITE_MASK;
            end
            if (i_req.addr == `PLD_IRQ_FLAGS_ADDR)
            begin
                clr_nxt = i_req.wdata;
            end
        end
        if (i_ce && i_req.rd)
        begin
            if (lut_hit)
            begin
                rdata_nxt = lut_r[lut_idx];
            end
            else if (i_req.addr == `PLD_ADV_ADDR)
            begin
                rdata_nxt = adv_r;
            end
            else
            begin
                rdata_nxt = `PLD_UNMAPPED_READ;
            end
            if (i_req.addr == `PLD_PIN_VALUE_ADDR
                && adv_r[`PLD_ADV_AUTOCLR_BIT])
            begin
                clr_nxt = `PLD_IRQ_CLEAR_ALL;
            end
        end
        if (!i_ce)
        begin
            clr_nxt = clr_r;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < 4; k++)
            begin
                lut_r[k] <= `PLD_LUT_RESET;
            end
            adv_r <= `PLD_ADV_RESET;
            rdata_r <= `PLD_UNMAPPED_READ;
            clr_r <= `PLD_IRQ_CLEAR_NONE;
        end
        else
        begin
            lut_r <= lut_nxt;
            adv_r <= adv_nxt;
            rdata_r <= rdata_nxt;
            clr_r <= clr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table lookups, one per driven pin.

    logic upper_on;
    logic lower_on;
    logic [3:0] sel_bit;
    logic [3:0] bank_on;
    logic [3:0] out_r;
    logic [3:0] out_nxt;
    logic [3:0] oe_r;
    logic [3:0] oe_nxt;
    logic boost_r;
    logic boost_nxt;

    assign upper_on = i_upper_bank_logic_mode == `PLD_MODE_3TO2;
    assign lower_on = i_lower_bank_logic_mode == `PLD_MODE_3TO2;

    // Even entries belong to the upper bank, odd ones to the lower bank.
    for (genvar g = 0; g < 4; g++)
    begin : g_lut
        assign bank_on[g] = (g % 2 == 0) ? upper_on : lower_on;
        pld_lut_select #(
            .SEL_W(SEL_W)
        ) u_sel (
            .i_table(lut_r[g]),
            .i_sel((g % 2 == 0) ? up_s2_r : lo_s2_r),
            .i_en(bank_on[g]),
            .o_bit(sel_bit[g])
        );
    end

    always_comb
    begin
        out_nxt = out_r;
        oe_nxt = oe_r;
        boost_nxt = boost_r;
        if (i_ce)
        begin
            out_nxt = sel_bit;
            oe_nxt = bank_on;
            boost_nxt = adv_nxt[`PLD_ADV_BOOST_BIT];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            out_r <= '0;
            oe_r <= '0;
            boost_r <= 1'b0;
        end
        else
        begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            boost_r <= boost_nxt;
        end
    end

    assign o_lut_out = out_r;
    assign o_lut_oe = oe_r;
    assign o_boost_en = boost_r;
    assign o_irq_clear_mask = clr_r;
    assign o_reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_upper_first;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && upper_on) |=> o_lut_out[0] == $past(lut_r[0][up_s2_r]);
    endproperty
    a_upper_first: assert property (p_upper_first)
        else $error("Pin 11 does not follow the upper first table.");

    property p_lower_first;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && lower_on) |=> o_lut_out[1] == $past(lut_r[1][lo_s2_r]);
    endproperty
    a_lower_first: assert property (p_lower_first)
        else $error("Pin 3 does not follow the lower first table.");

    property p_upper_second;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && upper_on) |=> o_lut_out[2] == $past(lut_r[2][up_s2_r]);
    endproperty
    a_upper_second: assert property (p_upper_second)
        else $error("Pin 12 does not follow the upper second table.");

    property p_lower_second;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && lower_on) |=> o_lut_out[3] == $past(lut_r[3][lo_s2_r]);
    endproperty
    a_lower_second: assert property (p_lower_second)
        else $error("Pin 4 does not follow the lower second table.");

    property p_mode_gate;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !upper_on && !lower_on) |=> (o_lut_oe == 4'h0
            && o_lut_out == 4'h0);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("A table acts outside 3-to-2 mode.");

    property p_autoclear;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_req.rd && i_req.addr == `PLD_PIN_VALUE_ADDR)
        |=> o_irq_clear_mask == ($past(adv_r[`PLD_ADV_AUTOCLR_BIT])
            ? `PLD_IRQ_CLEAR_ALL : `PLD_IRQ_CLEAR_NONE);
    endproperty
    a_autoclear: assert property (p_autoclear)
        else $error("Auto-clear on data read misbehaves.");

    property p_boost;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_req.wr && i_req.addr == `PLD_ADV_ADDR)
        |=> o_boost_en == $past(i_req.wdata[`PLD_ADV_BOOST_BIT]);
    endproperty
    a_boost: assert property (p_boost)
        else $error("Boost enable does not follow its setting bit.");

    property p_reset;
        @(posedge i_clk)
        i_rst |=> (adv_r == `PLD_ADV_RESET && lut_r[0] == `PLD_LUT_RESET
            && lut_r[1] == `PLD_LUT_RESET && lut_r[2] == `PLD_LUT_RESET
            && lut_r[3] == `PLD_LUT_RESET && !o_boost_en);
    endproperty
    a_reset: assert property (p_reset)
        else $error("Registers are not zero after reset.");

    property p_flag_clear;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_req.wr && !i_req.rd
            && i_req.addr == `PLD_IRQ_FLAGS_ADDR)
        |=> o_irq_clear_mask == $past(i_req.wdata) ##1
            (o_irq_clear_mask == `PLD_IRQ_CLEAR_NONE || !$past(i_ce)
             || $past(i_req.wr) || $past(i_req.rd));
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("Flag clear mask does not match the written ones.");

    property p_pin_follow;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && upper_on && !i_req.wr) [*3]
        |=> o_lut_out[0] == $past(lut_r[0][i_upper_sel_pins], 3);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("Lookup does not follow the pins within three cycles.");

endmodule

// >>> bench/pld_host_model.sv
// Host controller model that issues register writes and reads.
`timescale 1ns/1ps
`include "pld_lut_map.svh"
module pld_host_model
(
    // Clock and read data.
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    // Register requests.
    output pld_lut_pkg::reg_req_t o_req
);
    import pld_lut_pkg::*;

    initial o_req = '0;

    ////////////////////////////////////////////////////////////////////////
    // A legal host sends the reserved settings bits as zero.
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input bit legal);
        @(posedge i_clk);
        #1;
        if (legal && a == `PLD_ADV_ADDR)
            d = d & 8'h06;
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        #1;
        o_req = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        #1;
        d = i_rdata;
        o_req = '0;
    endtask

    // Service an event, then clear every pending flag by hand.
    task automatic service;
        logic [7:0] d;
        rd(`PLD_PIN_VALUE_ADDR, d);
        wr(`PLD_IRQ_FLAGS_ADDR, 8'hFF, 1'b1);
    endtask
endmodule

// >>> bench/pld_lookup_tables_and_advanced_cfg_tb.sv
// Self-checking bench for the lookup tables and advanced settings.
`timescale 1ns/1ps
`include "pld_lut_map.svh"
module pld_lookup_tables_and_advanced_cfg_tb;
    import pld_lut_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    reg_req_t req;
    logic [2:0] up_sel = 3'h0;
    logic [2:0] lo_sel = 3'h0;
    logic [1:0] up_mode = 2'h0;
    logic [1:0] lo_mode = 2'h0;
    logic [7:0] rdata;
    logic [7:0] clr_mask;
    logic [3:0] lut_out;
    logic [3:0] lut_oe;
    logic boost;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hed4f_8303;
    int tbl [4];
    int adv = 0;

    always #5 i_clk = ~i_clk;

    pld_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));

    pld_lut_regs i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_req(req), .o_reg_rdata(rdata), .i_upper_sel_pins(up_sel),
        .i_lower_sel_pins(lo_sel), .i_upper_bank_logic_mode(up_mode),
        .i_lower_bank_logic_mode(lo_mode), .o_lut_out(lut_out),
        .o_lut_oe(lut_oe), .o_boost_en(boost),
        .o_irq_clear_mask(clr_mask));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected pins 11, 3, 12, 4 (or their enables) from the model.
    function automatic logic [7:0] exp_lut(input bit oe);
        int u;
        int l;
        u = (up_mode == 2'h2);
        l = (lo_mode == 2'h2);
        if (oe)
            return 8'({l[0], u[0], l[0], u[0]});
        return 8'({l[0] & tbl[3][lo_sel], u[0] & tbl[2][up_sel],
                   l[0] & tbl[1][lo_sel], u[0] & tbl[0][up_sel]});
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, e);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        for (int i = 0; i < 4; i++)
            rd_chk(8'(8'h28 + i), 8'h00);
        rd_chk(`PLD_ADV_ADDR, 8'h00);
        rd_chk(8'h50, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            tbl[i] = rnd() & 32'h0000_00FF;
            i_host.wr(8'(8'h28 + i), 8'(tbl[i]), 1'b1);
            rd_chk(8'(8'h28 + i), 8'(tbl[i]));
        end
        // A frozen clock enable must drop a write.
        i_ce = 1'b0;
        i_host.wr(8'h28, ~8'(tbl[0]), 1'b1);
        i_ce = 1'b1;
        rd_chk(8'h28, 8'(tbl[0]));
        i_host.wr(`PLD_ADV_ADDR, 8'hFF, 1'b0);
        adv = 6;
        rd_chk(`PLD_ADV_ADDR, 8'h06);
        chk({7'h0, boost}, 8'(adv[1]));
        i_host.wr(`PLD_ADV_ADDR, 8'h00, 1'b1);
        adv = 0;
        chk({7'h0, boost}, 8'(adv[1]));
        for (int k = 0; k < 32; k++)
        begin
            up_mode = 2'(k / 8);
            lo_mode = 2'(3 - k / 8);
            up_sel = 3'(k);
            lo_sel = 3'(rnd());
            repeat (4) @(posedge i_clk);
            #1;
            chk(8'(lut_out), exp_lut(0));
            chk(8'(lut_oe), exp_lut(1));
        end
        i_host.wr(`PLD_ADV_ADDR, 8'h04, 1'b1);
        rd_chk(`PLD_PIN_VALUE_ADDR, 8'h00);
        chk(clr_mask, 8'hFF);
        @(posedge i_clk);
        #1;
        chk(clr_mask, 8'h00);
        i_host.wr(`PLD_ADV_ADDR, 8'h00, 1'b1);
        rd_chk(`PLD_PIN_VALUE_ADDR, 8'h00);
        chk(clr_mask, 8'h00);
        i_host.service();
        chk(clr_mask, 8'hFF);
        i_host.wr(`PLD_IRQ_FLAGS_ADDR, 8'h05, 1'b1);
        chk(clr_mask, 8'h05);
        // A second reset in mid-run clears the tables and settings again.
        i_host.wr(`PLD_ADV_ADDR, 8'h02, 1'b1);
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk({7'h0, boost}, 8'h00);
        for (int i = 0; i < 4; i++)
            rd_chk(8'(8'h28 + i), 8'h00);
        rd_chk(`PLD_ADV_ADDR, 8'h00);
        tally_and_finish();
    end
endmodule
